// >>> verilog/mbou_pkg.sv
// Purpose: Constants for the memory barrier ordering unit
// Assumes: Barrier instruction word presented by issue stage
// Notes: Field positions of the two mask fields
package mbou_pkg;
  // ----------------------------------------
  // Instruction fields
  // ----------------------------------------
  localparam int INSTR_W = 32;
  localparam int MMASK_LSB = 0;
  localparam int MMASK_W = 4;
  localparam int CMASK_LSB = 4;
  localparam int CMASK_W = 3;
  // ----------------------------------------
  // Ordering mask bits
  // ----------------------------------------
  localparam int LOAD_BEFORE_LOAD_BIT = 0;
  localparam int STORE_BEFORE_LOAD_BIT = 1;
  localparam int LOAD_BEFORE_STORE_BIT = 2;
  localparam int STORE_BEFORE_STORE_BIT = 3;
  // ----------------------------------------
  // Completion mask bits
  // ----------------------------------------
  localparam int LOOKASIDE_BIT = 0;
  localparam int MEMORY_ISSUE_BIT = 1;
  localparam int SYNC_BIT = 2;
  // ----------------------------------------
  // Stall states
  // ----------------------------------------
  typedef enum logic [1:0] {
    MBOU_IDLE,
    MBOU_WAIT_STORES,
    MBOU_WAIT_ALL
  } mbou_state_type;
endpackage

// >>> verilog/mbou_unit.sv
// Purpose: Carries out the memory barrier: decodes masks, stalls later issue
// Assumes: Completion inputs are synchronous levels from the memory side
// Notes: One barrier in flight; new barriers are taken only when idle
`timescale 1ns/1ps
module mbou_unit (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic barrier_valid,
  input wire logic [mbou_pkg::INSTR_W-1:0] barrier_instr,
  input wire logic stores_visible,
  input wire logic all_ops_done,
  output logic barrier_ready,
  output logic barrier_retire,
  output logic stall_loads,
  output logic stall_all,
  output logic [1:0] barrier_state
);
  // ----------------------------------------
  // Mask decode
  // ----------------------------------------
  logic [mbou_pkg::MMASK_W-1:0] mmask;
  logic [mbou_pkg::CMASK_W-1:0] cmask;
  // Per-bit flags of both masks
  logic load_before_load_bit;
  logic store_before_load_bit;
  logic load_before_store_bit;
  logic store_before_store_bit;
  logic sync_bit;
  logic memory_issue_bit;
  logic lookaside_bit;
  logic need_sync;
  logic need_store_wait;
  logic take;

  // Field extraction; bits outside the two fields are ignored
  assign mmask = barrier_instr[mbou_pkg::MMASK_LSB +: mbou_pkg::MMASK_W];
  assign cmask = barrier_instr[mbou_pkg::CMASK_LSB +: mbou_pkg::CMASK_W];

  // Ordering bits, each on its own, so any mix is legal
  assign load_before_load_bit = mmask[mbou_pkg::LOAD_BEFORE_LOAD_BIT];
  assign store_before_load_bit = mmask[mbou_pkg::STORE_BEFORE_LOAD_BIT];
  assign load_before_store_bit = mmask[mbou_pkg::LOAD_BEFORE_STORE_BIT];
  assign store_before_store_bit = mmask[mbou_pkg::STORE_BEFORE_STORE_BIT];

  // Completion bits
  assign sync_bit = cmask[mbou_pkg::SYNC_BIT];
  assign memory_issue_bit = cmask[mbou_pkg::MEMORY_ISSUE_BIT];
  assign lookaside_bit = cmask[mbou_pkg::LOOKASIDE_BIT];

  // Any completion bit means full sync; zero mask leaves ordering only
  assign need_sync = sync_bit || memory_issue_bit || lookaside_bit;
  // Only store-before-load waits; loads and stores already go in program order
  assign need_store_wait = store_before_load_bit;

  // ----------------------------------------
  // Stall state machine
  // ----------------------------------------
  // Current wait and one-cycle retire pulse
  mbou_pkg::mbou_state_type state_q, state_d;
  logic retire_d, retire_q;

  // Handshake: a barrier is taken only while idle
  assign barrier_ready = (state_q == mbou_pkg::MBOU_IDLE);
  assign take = barrier_valid && barrier_ready;

  // Next state from masks and completion reports
  always_comb begin
    state_d = state_q;
    retire_d = 1'b0;
    unique case (state_q)
      mbou_pkg::MBOU_IDLE: begin
        // Issue holds a barrier while busy, so only idle takes
        if (take) begin
          if (need_sync) begin
            state_d = mbou_pkg::MBOU_WAIT_ALL;
          end else if (need_store_wait) begin
            state_d = mbou_pkg::MBOU_WAIT_STORES;
          end else begin
            retire_d = 1'b1;
          end
        end
      end
      mbou_pkg::MBOU_WAIT_STORES: begin
        // Loads resume once earlier stores are visible
        if (stores_visible) begin
          state_d = mbou_pkg::MBOU_IDLE;
          retire_d = 1'b1;
        end
      end
      mbou_pkg::MBOU_WAIT_ALL: begin
        // Sync also covers earlier stores, so ordering holds too
        if (all_ops_done && stores_visible) begin
          state_d = mbou_pkg::MBOU_IDLE;
          retire_d = 1'b1;
        end
      end
      default: begin
        // Unused code: fall back to idle
        state_d = mbou_pkg::MBOU_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= mbou_pkg::MBOU_IDLE;
      retire_q <= 1'b0;
    end else begin
      state_q <= state_d;
      retire_q <= retire_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Stall outputs from state
  assign stall_loads = (state_q != mbou_pkg::MBOU_IDLE);
  assign stall_all = (state_q == mbou_pkg::MBOU_WAIT_ALL);
  assign barrier_retire = retire_q;
  assign barrier_state = state_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // No-op barrier retires next cycle with no stall
  a_noop_retires: assert property (@(posedge clk) disable iff (!rst_b)
    take && (cmask == '0) && !need_store_wait |=> barrier_retire && !stall_loads)
    else $error("no-op barrier did not retire next cycle");

  // Any completion bit gives the full stall
  a_sync_stalls_all: assert property (@(posedge clk) disable iff (!rst_b)
    take && need_sync |=> stall_all && stall_loads)
    else $error("sync barrier did not stall all issue");
  a_issue_bit_sync: assert property (@(posedge clk) disable iff (!rst_b)
    take && memory_issue_bit |=> stall_all)
    else $error("memory issue bit did not stall all");
  a_lookaside_is_sync: assert property (@(posedge clk) disable iff (!rst_b)
    take && lookaside_bit |=> stall_all)
    else $error("lookaside bit did not stall all");
  a_sync_loads_too: assert property (@(posedge clk) disable iff (!rst_b)
    stall_all |-> stall_loads)
    else $error("full stall let loads through");

  // Full stall holds until all earlier work and stores are done
  a_stall_until_done: assert property (@(posedge clk) disable iff (!rst_b)
    stall_all && !all_ops_done |=> stall_all)
    else $error("sync stall released before completion");
  a_sync_needs_stores: assert property (@(posedge clk) disable iff (!rst_b)
    stall_all && !stores_visible |=> stall_all)
    else $error("sync stall released before stores visible");
  a_busy_held: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == mbou_pkg::MBOU_WAIT_ALL && barrier_valid && !all_ops_done |=> stall_all)
    else $error("barrier taken while sync stall pending");
  a_wait_release: assert property (@(posedge clk) disable iff (!rst_b)
    stall_all && all_ops_done && stores_visible |=> !stall_all ##0 barrier_retire)
    else $error("sync stall not released on completion");

  // Store-before-load holds loads only, until stores are visible
  a_loads_wait_stores: assert property (@(posedge clk) disable iff (!rst_b)
    take && !need_sync && need_store_wait && !stores_visible |=> stall_loads && !stall_all)
    else $error("store-before-load did not hold loads");
  a_store_wait_holds: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == mbou_pkg::MBOU_WAIT_STORES && !stores_visible |=> stall_loads && !barrier_retire)
    else $error("loads released before stores visible");
  a_store_release: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == mbou_pkg::MBOU_WAIT_STORES && stores_visible |=> !stall_loads && barrier_retire)
    else $error("load stall not released on store visibility");
  a_store_only_loads: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == mbou_pkg::MBOU_WAIT_STORES |-> stall_loads && !stall_all)
    else $error("store wait stalled more than loads");

  // Ordering bits the pipeline already honours never stall
  a_free_bits_nostall: assert property (@(posedge clk) disable iff (!rst_b)
    take && (cmask == '0) && !mmask[mbou_pkg::STORE_BEFORE_LOAD_BIT] |=> !stall_loads)
    else $error("free ordering bit caused a stall");
  a_load_load_free: assert property (@(posedge clk) disable iff (!rst_b)
    take && !need_sync && !store_before_load_bit && load_before_load_bit |=> barrier_retire && !stall_loads)
    else $error("load-before-load bit caused a stall");
  a_load_store_free: assert property (@(posedge clk) disable iff (!rst_b)
    take && !need_sync && !store_before_load_bit && load_before_store_bit |=> barrier_retire && !stall_loads)
    else $error("load-before-store bit caused a stall");
  a_store_store_free: assert property (@(posedge clk) disable iff (!rst_b)
    take && !need_sync && !store_before_load_bit && store_before_store_bit |=> barrier_retire && !stall_loads)
    else $error("store-before-store bit caused a stall");
  a_cmask_zero_nosync: assert property (@(posedge clk) disable iff (!rst_b)
    take && (cmask == '0) |=> !stall_all)
    else $error("zero completion mask caused full stall");

  // Handshake: busy refuses, retire shows only while idle
  a_ready_low_busy: assert property (@(posedge clk) disable iff (!rst_b)
    stall_loads |-> !barrier_ready)
    else $error("ready shown while a barrier waits");
  a_retire_when_idle: assert property (@(posedge clk) disable iff (!rst_b)
    barrier_retire |-> barrier_ready && !stall_loads)
    else $error("retire shown while still stalled");

  // Main scenarios
  c_noop: cover property (@(posedge clk) disable iff (!rst_b)
    take && (cmask == '0) && !need_store_wait);
  c_store_wait: cover property (@(posedge clk) disable iff (!rst_b)
    state_q == mbou_pkg::MBOU_WAIT_STORES ##1 barrier_retire);
  c_sync_wait: cover property (@(posedge clk) disable iff (!rst_b)
    stall_all [*3] ##1 barrier_retire);
  c_held_take: cover property (@(posedge clk) disable iff (!rst_b)
    barrier_retire && take);
  c_all_cmask: cover property (@(posedge clk) disable iff (!rst_b)
    take && sync_bit && memory_issue_bit && lookaside_bit);
endmodule

// >>> bench/mbou_mem_model.sv
// Purpose: Memory side model giving completion levels to the barrier unit
// Assumes: Completion only counts while a barrier stall is shown
// Notes: Stores become visible before all operations are done
`timescale 1ns/1ps
module mbou_mem_model #(
  parameter int STORE_DLY = 3,
  parameter int OPS_DLY = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stall_loads,
  output logic stores_visible,
  output logic all_ops_done
);
  logic [7:0] wait_q;
  // Count cycles spent stalled, cleared when the stall drops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) wait_q <= 8'h00;
    else wait_q <= stall_loads ? wait_q + 8'h01 : 8'h00;
  end
  // Stores finish first, so a wait on the wrong level retires early
  assign stores_visible = stall_loads && (wait_q >= STORE_DLY);
  assign all_ops_done = stall_loads && (wait_q >= OPS_DLY);
endmodule

// >>> bench/memory_barrier_ordering_unit_tb.sv
// Purpose: Self-checking bench for the memory barrier ordering unit
// Assumes: Issue holds a barrier until the edge where it is taken
// Notes: Walks every ordering and completion mask value
`timescale 1ns/1ps
module memory_barrier_ordering_unit_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic barrier_valid = 1'b0;
  logic [31:0] barrier_instr = 32'h00000000;
  logic stores_visible, all_ops_done, barrier_ready, barrier_retire, stall_loads, stall_all;
  logic [1:0] barrier_state;
  int errors = 0;
  int samples_checked = 0;
  // Upper bits set on purpose; only the two mask fields may matter
  localparam logic [31:0] BARRIER_BASE = 32'hFFFFFF80;
  mbou_unit u_dut (.clk(clk), .rst_b(rst_b), .barrier_valid(barrier_valid), .barrier_instr(barrier_instr),
    .stores_visible(stores_visible), .all_ops_done(all_ops_done), .barrier_ready(barrier_ready),
    .barrier_retire(barrier_retire), .stall_loads(stall_loads), .stall_all(stall_all),
    .barrier_state(barrier_state));
  mbou_mem_model u_mem (.clk(clk), .rst_b(rst_b), .stall_loads(stall_loads),
    .stores_visible(stores_visible), .all_ops_done(all_ops_done));
  initial forever #12.5 clk = ~clk;
  // ----------------------------------------
  // Compare, verdict and barrier issue
  // ----------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task results();
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Wait for a retire pulse; a used-up bound counts a mismatch and ends the run
  task wait_retire();
    int k;
    k = 0;
    while (!barrier_retire && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    check(k < 50, 1'b1);
    if (k >= 50) results();
  endtask
  // Issue one barrier; a waiting one must not retire before its completion level
  task run(input logic [31:0] instr, input logic el, input logic ea);
    int n;
    logic seen;
    logic late;
    @(posedge clk);
    barrier_valid <= 1'b1;
    barrier_instr <= instr;
    @(posedge clk);
    barrier_valid <= 1'b0;
    #1;
    check(stall_loads, el);
    check(stall_all, ea);
    check(barrier_state, ea ? 2'h2 : {1'b0, el});
    check(barrier_retire, !el);
    check(barrier_ready, !el);
    n = 0;
    seen = 1'b0;
    late = 1'b0;
    while (el && !barrier_retire && n < 50) begin
      seen = ea ? (stores_visible && all_ops_done) : stores_visible;
      late = all_ops_done;
      @(posedge clk);
      #1;
      n++;
    end
    if (el) check(seen && n < 50, 1'b1);
    if (el && !ea) check(late, 1'b0);
    if (n >= 50) results();
    if (el) check(stall_loads | stall_all, 1'b0);
    @(posedge clk);
    #1;
    check(barrier_retire, 1'b0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check(barrier_ready, 1'b1);
    for (int m = 0; m < 16; m++) begin
      run(BARRIER_BASE | m, m[1], 1'b0);
    end
    for (int c = 1; c < 8; c++) begin
      run(BARRIER_BASE | (c << 4) | (c * 2), 1'b1, 1'b1);
    end
    // A barrier held while a sync waits is taken only once ready returns
    @(posedge clk);
    barrier_valid <= 1'b1;
    barrier_instr <= BARRIER_BASE | 32'h00000040;
    @(posedge clk);
    barrier_instr <= BARRIER_BASE;
    #1;
    check(barrier_ready, 1'b0);
    wait_retire();
    @(posedge clk);
    barrier_valid <= 1'b0;
    #1;
    check(barrier_retire, 1'b1);
    check(stall_loads, 1'b0);
    // Reset in the middle of a sync wait drops every stall
    @(posedge clk);
    barrier_valid <= 1'b1;
    barrier_instr <= BARRIER_BASE | 32'h00000010;
    @(posedge clk);
    barrier_valid <= 1'b0;
    #1;
    check(stall_all, 1'b1);
    @(posedge clk);
    rst_b <= 1'b0;
    #1;
    check({stall_loads, stall_all, barrier_retire, barrier_state}, 5'h00);
    check(barrier_ready, 1'b1);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    run(BARRIER_BASE | 32'h00000002, 1'b1, 1'b0);
    results();
  end
endmodule
